// >>> design/capture_adc_ext_priority.sv
// What this block does
// - capture 8 priority field at bits 14-12
// - capture 7 priority field at bits 10-8
// - external 1 priority field at bits 2-0
// - code 111 means level 7, highest
// - code 001 is level 1, lowest enabled
// - code 000 disables the source
// - bits 15, 11, 7, 3 read zero, ignore writes
`timescale 1ns/100ps
`include "prio5_cfg.svh"

module capture_adc_ext_priority
    import prio5_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_rst_n,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [15:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic [15:0]            o_rdata,
    output prio_out_t              o_prio
);

    // all state of the block in one record
    typedef struct packed {
        prio_fields_t fields;
        logic [15:0]  rdata;
        prio_out_t    prio;
    } state_t;

    state_t state;       // registered state
    state_t next_state;  // value for the next edge

    // pack fields into the register image; gaps stay zero
    function automatic logic [15:0] pack_fields(input prio_fields_t f);
        logic [15:0] img;
        img = 16'h0000;
        img[`PRIO5_CAP8_LSB  +: 3] = f.capture8_priority;
        img[`PRIO5_CAP7_LSB  +: 3] = f.capture7_priority;
        img[`PRIO5_CONV2_LSB +: 3] = f.converter2_done_priority;
        img[`PRIO5_EXT1_LSB  +: 3] = f.external1_priority;
        return img;
    endfunction

    // a source is enabled for any nonzero code
    function automatic logic is_enabled(input prio_level_t l);
        return l != `PRIO5_LEVEL_OFF;
    endfunction

    // one register only, so a full compare of the index is cheap; any other index
    // reads zero and swallows writes, which keeps stray software probes harmless
    wire logic hit = (i_addr == ADDR_W'(`PRIO5_REG_OFFSET));

    // next-state logic
    always_comb begin
        next_state = state;
        // a write only lands in the implemented fields
        if (i_wr && hit) begin
            next_state.fields.capture8_priority        = i_wdata[`PRIO5_CAP8_LSB  +: 3];
            next_state.fields.capture7_priority        = i_wdata[`PRIO5_CAP7_LSB  +: 3];
            next_state.fields.converter2_done_priority = i_wdata[`PRIO5_CONV2_LSB +: 3];
            next_state.fields.external1_priority       = i_wdata[`PRIO5_EXT1_LSB  +: 3];
        end
        // read data lives one cycle after the strobe only; unmapped reads give zero
        if (i_rd && hit) begin
            next_state.rdata = pack_fields(state.fields) & `PRIO5_IMPL_MASK;
        end else begin
            next_state.rdata = 16'h0000;
        end
        // the code is passed straight through as the level, 1..7 in order
        next_state.prio.level     = next_state.fields;
        next_state.prio.enable[3] = is_enabled(next_state.fields.capture8_priority);
        next_state.prio.enable[2] = is_enabled(next_state.fields.capture7_priority);
        next_state.prio.enable[1] = is_enabled(next_state.fields.converter2_done_priority);
        next_state.prio.enable[0] = is_enabled(next_state.fields.external1_priority);
    end

    // state register with synchronous reset
    // fields and the level copies on the outputs reset together, so the arbiter
    // never sees a level that software could not read back
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state.fields.capture8_priority        <= `PRIO5_FIELD_RESET;
            state.fields.capture7_priority        <= `PRIO5_FIELD_RESET;
            state.fields.converter2_done_priority <= `PRIO5_FIELD_RESET;
            state.fields.external1_priority       <= `PRIO5_FIELD_RESET;
            state.rdata                           <= 16'h0000;
            state.prio.level                      <= {4{`PRIO5_FIELD_RESET}};
            state.prio.enable                     <= 4'hf;
        end else begin
            state <= next_state;
        end
    end

    assign o_rdata = state.rdata;
    assign o_prio  = state.prio;

    // write lands in the capture 8 field next cycle
    property p_cap8_write;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_wr && hit) |=> (o_prio.level.capture8_priority == $past(i_wdata[14:12]));
    endproperty
    a_cap8_write: assert property (p_cap8_write) else $error("capture8 write lost");

    property p_cap7_write;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_wr && hit) |=> (o_prio.level.capture7_priority == $past(i_wdata[10:8]));
    endproperty
    a_cap7_write: assert property (p_cap7_write) else $error("capture7 write lost");

    property p_ext1_write;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_wr && hit) |=> (o_prio.level.external1_priority == $past(i_wdata[2:0]));
    endproperty
    a_ext1_write: assert property (p_ext1_write) else $error("external1 write lost");

    property p_conv2_readback;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_rd && hit && !$past(i_wr)) |=> (o_rdata[6:4] == o_prio.level.converter2_done_priority);
    endproperty
    a_conv2_readback: assert property (p_conv2_readback) else $error("converter2 readback");

    property p_max_level;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_wr && hit && i_wdata[14:12] == 3'h7)
            |=> (o_prio.enable[3] && o_prio.level.capture8_priority == 3'h7);
    endproperty
    a_max_level: assert property (p_max_level) else $error("code 7 not top level");

    property p_min_level;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_wr && hit && i_wdata[2:0] == 3'h1)
            |=> (o_prio.enable[0] && o_prio.level.external1_priority == 3'h1);
    endproperty
    a_min_level: assert property (p_min_level) else $error("code 1 not lowest level");

    property p_disable;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (o_prio.enable[2] == (o_prio.level.capture7_priority != 3'h0));
    endproperty
    a_disable: assert property (p_disable) else $error("enable disagrees with code");

    property p_gaps_zero;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        $past(i_rd) |-> (o_rdata[15] == 1'b0 && o_rdata[11] == 1'b0
                         && o_rdata[7] == 1'b0 && o_rdata[3] == 1'b0);
    endproperty
    a_gaps_zero: assert property (p_gaps_zero) else $error("unimplemented bit read one");

    property p_rdata_idle;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !(i_rd && hit) |=> (o_rdata == 16'h0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");

    // a write lands in the converter 2 field next cycle
    property p_conv2_write;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_wr && hit) |=> (o_prio.level.converter2_done_priority
                           == $past(i_wdata[`PRIO5_CONV2_LSB +: 3]));
    endproperty
    a_conv2_write: assert property (p_conv2_write) else $error("converter2 write lost");

    // read data is the level image of the cycle in which the strobe was taken
    property p_readback;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_rd && hit) |=> (o_rdata == {1'b0, $past(o_prio.level.capture8_priority),
                                       1'b0, $past(o_prio.level.capture7_priority),
                                       1'b0, $past(o_prio.level.converter2_done_priority),
                                       1'b0, $past(o_prio.level.external1_priority)});
    endproperty
    a_readback: assert property (p_readback) else $error("read image wrong");

    // without a write to this index the levels and enables never move
    property p_hold;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !(i_wr && hit) |=> $stable(o_prio);
    endproperty
    a_hold: assert property (p_hold) else $error("levels moved without a write");

    // every enable follows its own field, so a swapped enable line is caught
    property p_enable_all;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        o_prio.enable == {o_prio.level.capture8_priority != `PRIO5_LEVEL_OFF,
                          o_prio.level.capture7_priority != `PRIO5_LEVEL_OFF,
                          o_prio.level.converter2_done_priority != `PRIO5_LEVEL_OFF,
                          o_prio.level.external1_priority != `PRIO5_LEVEL_OFF};
    endproperty
    a_enable_all: assert property (p_enable_all) else $error("enable vector disagrees");

    // code 000 written to capture 8 takes its enable away
    property p_off_code;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_wr && hit && i_wdata[`PRIO5_CAP8_LSB +: 3] == `PRIO5_LEVEL_OFF)
            |=> !o_prio.enable[3];
    endproperty
    a_off_code: assert property (p_off_code) else $error("code 0 left source enabled");

    // code 111 on converter 2 is the top level with the source enabled
    property p_conv2_max;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_wr && hit && i_wdata[`PRIO5_CONV2_LSB +: 3] == `PRIO5_LEVEL_MAX)
            |=> (o_prio.enable[1]
                 && o_prio.level.converter2_done_priority == `PRIO5_LEVEL_MAX);
    endproperty
    a_conv2_max: assert property (p_conv2_max) else $error("code 7 wrong on converter2");

    // code 001 on capture 7 is the lowest enabled level
    property p_cap7_min;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (i_wr && hit && i_wdata[`PRIO5_CAP7_LSB +: 3] == 3'h1)
            |=> (o_prio.enable[2] && o_prio.level.capture7_priority == 3'h1);
    endproperty
    a_cap7_min: assert property (p_cap7_min) else $error("code 1 wrong on capture7");

    // reset loads priority 4 into every field and clears the read data
    // no disable here: this one watches the reset itself
    property p_reset_load;
        @(posedge i_core_clk)
        !i_rst_n |=> (o_rdata == 16'h0000 && o_prio.enable == 4'hf
                      && o_prio.level == {4{`PRIO5_FIELD_RESET}});
    endproperty
    a_reset_load: assert property (p_reset_load) else $error("reset image wrong");

endmodule

// >>> design/prio5_cfg.svh
`ifndef PRIO5_CFG_SVH
`define PRIO5_CFG_SVH

// register offset (word index on the plain register port)
`define PRIO5_REG_OFFSET      4'h0
// field positions (low bit of each 3-bit field)
`define PRIO5_CAP8_LSB        12
`define PRIO5_CAP7_LSB        8
`define PRIO5_CONV2_LSB       4
`define PRIO5_EXT1_LSB        0
// field reset values (priority 4 each, as at power-on)
`define PRIO5_FIELD_RESET     3'h4
// mask of implemented bits; bits 15, 11, 7 and 3 are absent
`define PRIO5_IMPL_MASK       16'h7777
// field codes with special meaning
`define PRIO5_LEVEL_OFF       3'h0
`define PRIO5_LEVEL_MAX       3'h7

`endif

// >>> design/prio5_pkg.sv
package prio5_pkg;

    // one priority field: 0 disables, 1..7 is the level
    typedef logic [2:0] prio_level_t;

    // the four sources held by the register
    typedef struct packed {
        prio_level_t capture8_priority;
        prio_level_t capture7_priority;
        prio_level_t converter2_done_priority;
        prio_level_t external1_priority;
    } prio_fields_t;

    // per-source level and enable seen by the arbiter
    typedef struct packed {
        logic [3:0]  enable;
        prio_fields_t level;
    } prio_out_t;

endpackage

// >>> tb/capture_adc_ext_priority_bench.sv
`timescale 1ns/100ps
// drives the register port directly and checks read data and per-source outputs
module capture_adc_ext_priority_bench
    import prio5_pkg::*;
;
    logic        i_core_clk = 1'b0;   // 100 MHz core clock
    logic        i_rst_n    = 1'b0;   // synchronous reset, held low at start
    logic [3:0]  i_addr     = 4'h0;   // register index
    logic [15:0] i_wdata    = 16'h0000;
    logic        i_wr       = 1'b0;
    logic        i_rd       = 1'b0;
    logic [15:0] o_rdata;
    prio_out_t   o_prio;
    int          n_fail     = 0;
    int          tests_run  = 0;

    always #5 i_core_clk = ~i_core_clk;

    capture_adc_ext_priority uut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_prio(o_prio));

    task automatic chk_data(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_prio(input string name, input prio_out_t exp);
        tests_run++;
        if (o_prio !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, o_prio);
        end
    endtask

    // one-cycle write strobe; returns on the edge that takes it
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_core_clk);
        i_wr    <= 1'b0;
        #1;
    endtask

    // data must stand only in the cycle after the strobe, zero again after
    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string name);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_core_clk);
        i_rd   <= 1'b0;
        #1 chk_data(name, exp, o_rdata);
        @(posedge i_core_clk);
        #1 chk_data("rdata_idle", 16'h0000, o_rdata);
    endtask

    task automatic test_fields();
        rd(4'h0, 16'h4444, "reset_value");
        chk_prio("reset_prio", 16'hf924);
        wr(4'h0, 16'h1357);
        chk_prio("prio_1357", 16'hf2ef);
        rd(4'h0, 16'h1357, "read_1357");
        wr(4'h0, 16'h7531);
        chk_prio("prio_7531", 16'hff59);
        $display("test_fields done");
    endtask

    // every code in every field; zero must drop all four enables
    task automatic test_codes();
        logic [2:0] c;
        for (int k = 0; k < 8; k++) begin
            c = 3'(k);
            wr(4'h0, {4{1'b0, c}});
            chk_prio("prio_code", {(c != 3'h0) ? 4'hf : 4'h0, {4{c}}});
            rd(4'h0, {4{1'b0, c}}, "read_code");
        end
        $display("test_codes done");
    endtask

    task automatic test_reserved();
        wr(4'h0, 16'hffff);
        rd(4'h0, 16'h7777, "read_ones");
        chk_prio("prio_ones", 16'hffff);
        wr(4'h0, 16'h8888);
        rd(4'h0, 16'h0000, "read_gaps");
        chk_prio("prio_gaps", 16'h0000);
        // mixed zero and nonzero codes: each enable must follow its own field
        wr(4'h0, 16'h0107);
        chk_prio("prio_mixed", 16'h5047);
        rd(4'h0, 16'h0107, "read_mixed");
        $display("test_reserved done");
    endtask

    // an unmapped write must not leak into the register
    task automatic test_unmapped();
        wr(4'h0, 16'h1357);
        wr(4'h5, 16'h7777);
        rd(4'h5, 16'h0000, "read_unmapped");
        rd(4'h0, 16'h1357, "read_kept");
        chk_prio("prio_kept", 16'hf2ef);
        $display("test_unmapped done");
    endtask

    // a reset in mid-run must bring back the power-on image
    task automatic test_reset();
        wr(4'h0, 16'h1357);
        @(posedge i_core_clk);
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        #1 chk_prio("prio_after_reset", 16'hf924);
        rd(4'h0, 16'h4444, "read_after_reset");
        $display("test_reset done");
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // guards against a hang; the run itself needs far fewer cycles
    initial begin
        #200000;
        n_fail++;
        test_done();
    end

    initial begin
        repeat (3) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        test_fields();
        test_codes();
        test_reserved();
        test_unmapped();
        test_reset();
        test_done();
    end
endmodule
